// [rtl/alu_exec_defs.vh]
// Shared constants for the instruction execution datapath
`ifndef ALU_EXEC_DEFS_VH
`define ALU_EXEC_DEFS_VH

// Opcode fields, compared against the top bits of the 14-bit word
`define OPC_ADD_ACC_TO_FILE     6'h07
`define OPC_AND_ACC_WITH_FILE   6'h05
`define OPC_CLEAR_FILE_REGISTER 7'h03
`define OPC_BIT_CLEAR_FILE      4'h4
`define OPC_BIT_SET_FILE        4'h5
`define OPC_BIT_TEST_SKIP       4'h7
`define OPC_ADD_LITERAL         5'h1f
`define OPC_AND_LITERAL         6'h39

// One-hot operation select bit positions
`define OPS_WIDTH     8
`define OPS_ADD_LIT   0
`define OPS_ADD_FILE  1
`define OPS_AND_LIT   2
`define OPS_AND_FILE  3
`define OPS_BCLR      4
`define OPS_BSET      5
`define OPS_BTSKIP    6
`define OPS_CLR_FILE  7

// Instruction word field positions
`define FLD_DEST      7
`define FLD_BIT_HI    9
`define FLD_BIT_LO    7
`define FLD_ADDR_HI   6
`define FLD_ADDR_LO   0
`define FLD_LIT_HI    7
`define FLD_LIT_LO    0

// Software port map
`define SW_ACC_ADDR   8'h80
`define SW_STAT_ADDR  8'h81

// Status register bit positions
`define STAT_C        0
`define STAT_DC       1
`define STAT_Z        2

// Reset values
`define ACC_RESET     8'h00
`define FILE_RESET    8'h00
`define STAT_RESET    3'h0

// Oscillator periods per instruction cycle
`define OSC_PER_CYCLE 4

`endif

// [rtl/alu_bit_unit.v]
// Combinational arithmetic, logic and bit unit for one instruction
`timescale 1ns/1ps
`include "alu_exec_defs.vh"

module alu_bit_unit (
  op,
  acc,
  opnd,
  lit,
  bit_idx,
  result,
  carry,
  dcarry,
  zero,
  skip
);
  input  wire [`OPS_WIDTH-1:0] op;
  input  wire [7:0]            acc;
  input  wire [7:0]            opnd;
  input  wire [7:0]            lit;
  input  wire [2:0]            bit_idx;
  output reg  [7:0]            result;
  output reg                   carry;
  output reg                   dcarry;
  output reg                   zero;
  output reg                   skip;

  reg [7:0] addend;
  reg [8:0] sum;
  reg [4:0] nib;
  reg [7:0] mask;

  // Operation select and flag generation
  always @* begin
    addend = op[`OPS_ADD_LIT] ? lit : opnd;
    sum    = {1'b0, acc} + {1'b0, addend};
    nib    = {1'b0, acc[3:0]} + {1'b0, addend[3:0]};
    mask   = 8'h01 << bit_idx;
    result = opnd;
    skip   = 1'b0;
    if (op[`OPS_ADD_LIT] || op[`OPS_ADD_FILE]) begin
      result = sum[7:0];
    end else if (op[`OPS_AND_LIT]) begin
      result = acc & lit;
    end else if (op[`OPS_AND_FILE]) begin
      result = acc & opnd;
    end else if (op[`OPS_BCLR]) begin
      result = opnd & ~mask;
    end else if (op[`OPS_BSET]) begin
      result = opnd | mask;
    end else if (op[`OPS_BTSKIP]) begin
      skip = |(opnd & mask);
    end else if (op[`OPS_CLR_FILE]) begin
      result = 8'h00;
    end
    carry  = sum[8];
    dcarry = nib[4];
    zero   = (result == 8'h00);
  end

endmodule

// [rtl/alu_exec_core.v]
// Execution datapath with data file, working register and status flags
`timescale 1ns/1ps
`include "alu_exec_defs.vh"

// What this block does
// - Add literal to acc, result in acc
// - Add acc and file, to destination
// - Destination bit: 0 acc, 1 file
// - AND acc with file, zero flag only
// - AND literal with acc, zero flag only
// - Bit clear leaves other bits, flags
// - Bit set leaves other bits, flags
// - Tested bit one discards next instruction
// - Tested bit zero continues, flags untouched
// - Clear file writes zero, sets zero
// - Four clocks per instruction cycle
module alu_exec_core #(
  parameter FILE_DEPTH = 128,
  parameter ADDR_W     = 7
) (
  mclk,
  rst,
  instr_word,
  instr_valid,
  sw_addr,
  sw_wdata,
  sw_wr,
  sw_rd,
  sw_rdata,
  instr_take,
  nop_slot,
  acc,
  carry_flag,
  digit_carry_flag,
  zero_flag
);
  input  wire        mclk;
  input  wire        rst;
  input  wire [13:0] instr_word;
  input  wire        instr_valid;
  input  wire [7:0]  sw_addr;
  input  wire [7:0]  sw_wdata;
  input  wire        sw_wr;
  input  wire        sw_rd;
  output wire [7:0]  sw_rdata;
  output wire        instr_take;
  output wire        nop_slot;
  output wire [7:0]  acc;
  output wire        carry_flag;
  output wire        digit_carry_flag;
  output wire        zero_flag;

  //////////////////////////////////////////////////////////////////////////////
  // Phase states of one instruction cycle, one-hot
  localparam ST_READ  = 4'h1;
  localparam ST_CALC  = 4'h2;
  localparam ST_WRITE = 4'h4;
  localparam ST_FETCH = 4'h8;

  reg [3:0]            state_q;
  reg [3:0]            state_d;
  reg [13:0]           ir_q;
  reg [`OPS_WIDTH-1:0] op_q;
  reg [7:0]            opnd_q;
  reg [7:0]            res_q;
  reg                  res_c_q;
  reg                  res_dc_q;
  reg                  res_z_q;
  reg                  res_skip_q;
  reg [7:0]            acc_q;
  reg                  c_q;
  reg                  dc_q;
  reg                  z_q;
  reg                  skip_q;
  reg                  nop_slot_q;
  reg                  take_q;
  reg [7:0]            rdata_q;
  reg [7:0]            file_q [0:FILE_DEPTH-1];

  wire [7:0]  alu_res;
  wire        alu_c;
  wire        alu_dc;
  wire        alu_z;
  wire        alu_skip;
  wire [ADDR_W-1:0] f_addr;
  wire        dest_bit;
  wire        to_file;
  wire        to_acc;
  wire        upd_z;
  wire        upd_cdc;

  integer i;

  //////////////////////////////////////////////////////////////////////////////
  // Instruction decode into a one-hot operation select
  function [`OPS_WIDTH-1:0] decode_op;
    input [13:0] w;
    begin
      decode_op = {`OPS_WIDTH{1'b0}};
      decode_op[`OPS_ADD_FILE] = (w[13:8] == `OPC_ADD_ACC_TO_FILE);
      decode_op[`OPS_AND_FILE] = (w[13:8] == `OPC_AND_ACC_WITH_FILE);
      decode_op[`OPS_CLR_FILE] = (w[13:7] == `OPC_CLEAR_FILE_REGISTER);
      decode_op[`OPS_BCLR]   = (w[13:10] == `OPC_BIT_CLEAR_FILE);
      decode_op[`OPS_BSET]   = (w[13:10] == `OPC_BIT_SET_FILE);
      decode_op[`OPS_BTSKIP] = (w[13:10] == `OPC_BIT_TEST_SKIP);
      decode_op[`OPS_ADD_LIT] = (w[13:9] == `OPC_ADD_LITERAL);
      decode_op[`OPS_AND_LIT] = (w[13:8] == `OPC_AND_LITERAL);
    end
  endfunction

  // Software map test for file locations
  function is_file_addr;
    input [7:0] a;
    begin
      is_file_addr = (a < FILE_DEPTH);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Operand fields of the latched instruction
  assign f_addr   = ir_q[`FLD_ADDR_HI:`FLD_ADDR_LO];
  assign dest_bit = ir_q[`FLD_DEST];

  // Destination and flag update selection
  assign to_file = ((op_q[`OPS_ADD_FILE] | op_q[`OPS_AND_FILE]) & dest_bit)
                 | op_q[`OPS_BCLR] | op_q[`OPS_BSET] | op_q[`OPS_CLR_FILE];
  assign to_acc  = ((op_q[`OPS_ADD_FILE] | op_q[`OPS_AND_FILE]) & ~dest_bit)
                 | op_q[`OPS_ADD_LIT] | op_q[`OPS_AND_LIT];
  assign upd_cdc = op_q[`OPS_ADD_LIT] | op_q[`OPS_ADD_FILE];
  assign upd_z   = upd_cdc | op_q[`OPS_AND_LIT] | op_q[`OPS_AND_FILE]
                 | op_q[`OPS_CLR_FILE];

  //////////////////////////////////////////////////////////////////////////////
  // Arithmetic and bit unit
  alu_bit_unit u_alu (
    .op      (op_q),
    .acc     (acc_q),
    .opnd    (opnd_q),
    .lit     (ir_q[`FLD_LIT_HI:`FLD_LIT_LO]),
    .bit_idx (ir_q[`FLD_BIT_HI:`FLD_BIT_LO]),
    .result  (alu_res),
    .carry   (alu_c),
    .dcarry  (alu_dc),
    .zero    (alu_z),
    .skip    (alu_skip)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Phase sequencer, four clocks per instruction
  always @* begin
    case (state_q)
      ST_READ:  state_d = ST_CALC;
      ST_CALC:  state_d = ST_WRITE;
      ST_WRITE: state_d = ST_FETCH;
      ST_FETCH: state_d = ST_READ;
      default:  state_d = ST_READ;
    endcase
  end

  // State register and fetch indicator
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ST_FETCH;
      take_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      take_q  <= (state_d == ST_FETCH);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Instruction latch, squashing the slot after a taken skip
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ir_q       <= 14'h0000;
      op_q       <= {`OPS_WIDTH{1'b0}};
      nop_slot_q <= 1'b0;
    end else if (take_q) begin                          // Not the phase left by reset
      ir_q       <= instr_word;
      nop_slot_q <= skip_q;
      if (instr_valid && !skip_q) begin
        op_q <= decode_op(instr_word);
      end else begin
        op_q <= {`OPS_WIDTH{1'b0}};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Operand read and result capture
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      opnd_q     <= 8'h00;
      res_q      <= 8'h00;
      res_c_q    <= 1'b0;
      res_dc_q   <= 1'b0;
      res_z_q    <= 1'b0;
      res_skip_q <= 1'b0;
    end else begin
      if (state_q == ST_READ) begin
        opnd_q <= file_q[f_addr];
      end
      if (state_q == ST_CALC) begin
        res_q      <= alu_res;
        res_c_q    <= alu_c;
        res_dc_q   <= alu_dc;
        res_z_q    <= op_q[`OPS_CLR_FILE] | alu_z;
        res_skip_q <= alu_skip;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Data file: software writes, then instruction write-back wins
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < FILE_DEPTH; i = i + 1) begin
        file_q[i] <= `FILE_RESET;
      end
    end else begin
      if (sw_wr && is_file_addr(sw_addr)) begin
        file_q[sw_addr[ADDR_W-1:0]] <= sw_wdata;
      end
      if (state_q == ST_WRITE && to_file) begin
        file_q[f_addr] <= res_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Working register and status flags
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_q <= `ACC_RESET;
      c_q   <= 1'b0;
      dc_q  <= 1'b0;
      z_q   <= 1'b0;
    end else begin
      if (sw_wr && sw_addr == `SW_ACC_ADDR) begin
        acc_q <= sw_wdata;
      end
      if (sw_wr && sw_addr == `SW_STAT_ADDR) begin
        c_q  <= sw_wdata[`STAT_C];
        dc_q <= sw_wdata[`STAT_DC];
        z_q  <= sw_wdata[`STAT_Z];
      end
      if (state_q == ST_WRITE) begin
        if (to_acc) begin
          acc_q <= res_q;
        end
        if (upd_cdc) begin
          c_q  <= res_c_q;
          dc_q <= res_dc_q;
        end
        if (upd_z) begin
          z_q <= res_z_q;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Skip request held until the next fetch consumes it
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      skip_q <= 1'b0;
    end else if (state_q == ST_WRITE) begin
      skip_q <= op_q[`OPS_BTSKIP] & res_skip_q;
    end else if (state_q == ST_FETCH) begin
      skip_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software read port, data valid in the following cycle only
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (sw_rd) begin
      if (is_file_addr(sw_addr)) begin
        rdata_q <= file_q[sw_addr[ADDR_W-1:0]];
      end else if (sw_addr == `SW_ACC_ADDR) begin
        rdata_q <= acc_q;
      end else if (sw_addr == `SW_STAT_ADDR) begin
        rdata_q <= {5'h00, z_q, dc_q, c_q};
      end else begin
        rdata_q <= 8'h00;                               // Unmapped reads zero
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign sw_rdata         = rdata_q;
  assign instr_take       = take_q;
  assign nop_slot         = nop_slot_q;
  assign acc              = acc_q;
  assign carry_flag       = c_q;
  assign digit_carry_flag = dc_q;
  assign zero_flag        = z_q;

endmodule

// [test/alu_exec_core_sva.sv]
// Assertions on the execution datapath ports
`timescale 1ns/1ps
module alu_exec_core_chk (
  input wire        mclk,
  input wire        rst,
  input wire [13:0] instr_word,
  input wire        instr_valid,
  input wire [7:0]  sw_addr,
  input wire [7:0]  sw_wdata,
  input wire        sw_wr,
  input wire        sw_rd,
  input wire [7:0]  sw_rdata,
  input wire        instr_take,
  input wire        nop_slot,
  input wire [7:0]  acc,
  input wire        carry_flag,
  input wire        digit_carry_flag,
  input wire        zero_flag
);
  reg  [13:0] w_q;
  reg  [7:0]  a_q;
  reg  [2:0]  f_q;
  reg         ok_q;
  wire [2:0]  fl   = {zero_flag, digit_carry_flag, carry_flag};
  wire [8:0]  sum  = {1'b0, a_q} + {1'b0, w_q[7:0]};
  // A discarded slot shows nop_slot while it runs, up to its closing take
  wire        done = instr_take && ok_q && !nop_slot;
  wire        done_skip = done && w_q[13:10] == 4'h7;
  ////////////////////////////////////////////////////////////////
  // Taken word with the state it starts from
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      w_q  <= 14'h0000;
      a_q  <= 8'h00;
      f_q  <= 3'h0;
      ok_q <= 1'b0;
    end else if (instr_take) begin
      w_q  <= instr_word;
      a_q  <= acc;
      f_q  <= fl;
      ok_q <= instr_valid;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  take_period_a: assert property (
    instr_take |=> !instr_take [*3] ##1 instr_take) else $error("take spacing wrong");
  acc_hold_a: assert property (
    !$stable(acc) && !$past(sw_wr) |-> instr_take) else $error("acc moved off slot end");
  flag_hold_a: assert property (
    !$stable(fl) && !$past(sw_wr) |-> instr_take) else $error("flags moved off slot end");
  add_lit_a: assert property (
    done && w_q[13:9] == 5'h1f |-> {carry_flag, acc} == sum && zero_flag == (acc == 8'h00))
    else $error("add literal result wrong");
  add_dcarry_a: assert property (
    done && w_q[13:9] == 5'h1f |-> digit_carry_flag == (sum[4] ^ a_q[4] ^ w_q[4]))
    else $error("digit carry wrong");
  and_lit_a: assert property (
    done && w_q[13:8] == 6'h39 |-> acc == (a_q & w_q[7:0]) && fl[1:0] == f_q[1:0])
    else $error("and literal wrong");
  bit_flags_a: assert property (
    done && (w_q[13:11] == 3'h2 || w_q[13:10] == 4'h7) |-> fl == f_q)
    else $error("bit op moved flags");
  clr_zero_a: assert property (
    done && w_q[13:7] == 7'h03 |-> zero_flag && fl[1:0] == f_q[1:0])
    else $error("clear file flags wrong");
  nop_len_a: assert property (
    $rose(nop_slot) |-> nop_slot [*4] ##1 !nop_slot) else $error("discard slot length");
  nop_cause_a: assert property (
    $rose(nop_slot) |-> $past(done_skip)) else $error("discard without skip");
  rd_idle_a: assert property (
    !$past(sw_rd) |-> sw_rdata == 8'h00) else $error("read data outside slot");
endmodule
bind alu_exec_core alu_exec_core_chk u_chk (
  .mclk(mclk), .rst(rst), .instr_word(instr_word), .instr_valid(instr_valid),
  .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
  .sw_rdata(sw_rdata), .instr_take(instr_take), .nop_slot(nop_slot), .acc(acc),
  .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag)
);

// [test/fetch_model.sv]
// Fetch side model presenting one word per instruction slot
`timescale 1ns/1ps
module fetch_model (
  input  wire        instr_take,
  input  wire [13:0] word_in,
  input  wire        valid_in,
  output wire [13:0] instr_word,
  output wire        instr_valid
);
  // Word only in the take cycle, inverse otherwise to expose late sampling
  assign instr_word  = instr_take ? word_in : ~word_in;
  assign instr_valid = instr_take ? valid_in : ~valid_in;
endmodule

// [test/mcu_alu_bit_ops_exec_bench.sv]
// Self-checking bench for the execution datapath
`timescale 1ns/1ps
`include "alu_exec_defs.vh"
module mcu_alu_bit_ops_exec_bench;
  reg         mclk = 1'b0;
  reg         rst = 1'b1;
  reg  [13:0] word_in = 14'h0000;
  reg         valid_in = 1'b0;
  reg  [7:0]  sw_addr = 8'h00;
  reg  [7:0]  sw_wdata = 8'h00;
  reg         sw_wr = 1'b0;
  reg         sw_rd = 1'b0;
  reg  [7:0]  rd_q, nop_cnt = 8'h00, n0, ex;
  integer     mismatches = 0, samples_checked = 0, b;
  wire [13:0] instr_word;
  wire [7:0]  sw_rdata, acc;
  wire        instr_valid, instr_take, nop_slot, carry_flag, digit_carry_flag, zero_flag;
  ////////////////////////////////////////////////////////////////
  alu_exec_core DUT (.mclk(mclk), .rst(rst), .instr_word(instr_word),
    .instr_valid(instr_valid), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .instr_take(instr_take), .nop_slot(nop_slot),
    .acc(acc), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
    .zero_flag(zero_flag));
  fetch_model u_fetch (.instr_take(instr_take), .word_in(word_in), .valid_in(valid_in),
    .instr_word(instr_word), .instr_valid(instr_valid));
  // Clock and discarded slot counter
  initial begin
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (nop_slot === 1'b1) nop_cnt <= nop_cnt + 8'h01;
  end
  ////////////////////////////////////////////////////////////////
  task final_report;
    begin
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task chkf(input c, input d, input z);
    chk({5'h00, zero_flag, digit_carry_flag, carry_flag}, {5'h00, z, d, c});
  endtask
  task sw_write(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_wr    <= 1'b1;
      @(posedge mclk);
      sw_wr    <= 1'b0;
    end
  endtask
  task sw_read(input [7:0] a);
    begin
      @(posedge mclk);
      sw_addr <= a;
      sw_rd   <= 1'b1;
      @(posedge mclk);
      sw_rd   <= 1'b0;
      @(negedge mclk);
      rd_q = sw_rdata;
    end
  endtask
  // Present a word and return at the edge that takes it
  task issue(input [13:0] w);
    integer n;
    begin
      @(posedge mclk);
      word_in  <= w;
      valid_in <= 1'b1;
      n = 0;
      @(posedge mclk);
      while (instr_take !== 1'b1 && n < 8) begin
        n = n + 1;
        @(posedge mclk);
      end
      if (n == 8) begin
        mismatches = mismatches + 1;
        final_report;
      end
    end
  endtask
  task run(input [13:0] w);
    begin
      issue(w);
      @(posedge mclk);
      valid_in <= 1'b0;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task t_add;
    begin
      sw_write(`SW_ACC_ADDR, 8'h8f);
      run({`OPC_ADD_LITERAL, 1'b0, 8'h71});
      chk(acc, 8'h00);
      chkf(1'b1, 1'b1, 1'b1);
      run({`OPC_ADD_LITERAL, 1'b1, 8'hff});
      chk(acc, 8'hff);
      chkf(1'b0, 1'b0, 1'b0);
      sw_write(8'h05, 8'hff);
      sw_write(`SW_ACC_ADDR, 8'h01);
      run({`OPC_ADD_ACC_TO_FILE, 1'b1, 7'h05});
      sw_read(8'h05);
      chk(rd_q, 8'h00);
      chk(acc, 8'h01);
      chkf(1'b1, 1'b1, 1'b1);
      sw_write(8'h7f, 8'h08);
      sw_write(`SW_ACC_ADDR, 8'h08);
      run({`OPC_ADD_ACC_TO_FILE, 1'b0, 7'h7f});
      chk(acc, 8'h10);
      chkf(1'b0, 1'b1, 1'b0);
      sw_read(8'h7f);
      chk(rd_q, 8'h08);
      $display("test add done");
    end
  endtask
  task t_and;
    begin
      sw_write(8'h10, 8'hf0);
      sw_write(`SW_ACC_ADDR, 8'h0f);
      sw_write(`SW_STAT_ADDR, 8'h03);
      run({`OPC_AND_ACC_WITH_FILE, 1'b0, 7'h10});
      chk(acc, 8'h00);
      chkf(1'b1, 1'b1, 1'b1);
      sw_write(`SW_ACC_ADDR, 8'h3c);
      run({`OPC_AND_LITERAL, 8'h0f});
      chk(acc, 8'h0c);
      chkf(1'b1, 1'b1, 1'b0);
      run({`OPC_AND_ACC_WITH_FILE, 1'b1, 7'h10});
      sw_read(8'h10);
      chk(rd_q, 8'h00);
      chk(acc, 8'h0c);
      $display("test and done");
    end
  endtask
  task t_bits;
    begin
      sw_write(8'h20, 8'h5a);
      sw_write(`SW_STAT_ADDR, 8'h05);
      ex = 8'h5a;
      for (b = 0; b < 16; b = b + 1) begin
        run({(b < 8) ? `OPC_BIT_SET_FILE : `OPC_BIT_CLEAR_FILE, b[2:0], 7'h20});
        ex[b[2:0]] = (b < 8);
        sw_read(8'h20);
        chk(rd_q, ex);
      end
      chkf(1'b1, 1'b0, 1'b1);
      $display("test bits done");
    end
  endtask
  task t_skip;
    begin
      sw_write(8'h30, 8'h80);
      sw_write(`SW_ACC_ADDR, 8'h40);
      sw_write(`SW_STAT_ADDR, 8'h02);
      n0 = nop_cnt;
      issue({`OPC_BIT_TEST_SKIP, 3'h7, 7'h30});
      run({`OPC_ADD_LITERAL, 1'b0, 8'h01});
      chk(acc, 8'h40);
      chkf(1'b0, 1'b1, 1'b0);
      sw_read(8'h30);
      chk(nop_cnt - n0, 8'h04);
      issue({`OPC_BIT_TEST_SKIP, 3'h0, 7'h30});
      run({`OPC_ADD_LITERAL, 1'b0, 8'h01});
      sw_read(8'h30);
      chk(acc, 8'h41);
      chk(nop_cnt - n0, 8'h04);
      $display("test skip done");
    end
  endtask
  task t_clear;
    begin
      sw_write(8'h7f, 8'ha5);
      sw_write(`SW_STAT_ADDR, 8'h00);
      run({`OPC_CLEAR_FILE_REGISTER, 7'h7f});
      sw_read(8'h7f);
      chk(rd_q, 8'h00);
      sw_read(`SW_STAT_ADDR);
      chk(rd_q, 8'h04);
      sw_read(8'h90);
      chk(rd_q, 8'h00);
      $display("test clear done");
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_add;
    t_and;
    t_bits;
    t_skip;
    t_clear;
    final_report;
  end
endmodule
